// *** inc/ssp_params.svh ***
/*
 Timing counts, offsets, format codes and reset values for the serial port.
 Assumes inclusion by bare name from a design file; definitions only.
*/
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_OFF_CTRL0      8'h00
`define SSP_OFF_CTRL1      8'h04
`define SSP_OFF_IRQ        8'h08
`define SSP_OFF_DATA       8'h0C
`define SSP_OFF_PRESC      8'h10
`define SSP_OFF_STAT       8'h14
`define SSP_OFF_OVR_CLR    8'h08
`define SSP_CTRL0_RST      16'h0000
`define SSP_CTRL1_RST      8'h00
`define SSP_PRESC_RST      8'h04
`define SSP_FMT_SPI        2'h0
`define SSP_FMT_PULSE      2'h1
`define SSP_FMT_CTRLW      2'h2
`define SSP_CW_BITS        5'h08
`define SSP_FIFO_DEPTH     4'h8
`define SSP_WATERMARK      4'h4
`define SSP_SYS_HZ         200000000
`define SSP_BASE_HZ        7372800
`define SSP_BASE_DIV       ((`SSP_SYS_HZ + `SSP_BASE_HZ - 1) / `SSP_BASE_HZ)
`endif

// *** inc/ssp_pkg.sv ***
/*
 Types shared by the serial port design.
 Assumes the parameter header supplies all numeric constants.
*/
package ssp_pkg;
   typedef enum logic [3:0] {
      SSP_IDLE  = 4'b0001,
      SSP_LOAD  = 4'b0010,
      SSP_SHIFT = 4'b0100,
      SSP_GAP   = 4'b1000
   } ssp_state_e;

   typedef struct packed {
      logic       sclk;
      logic       frame;
      logic       mosi;
   } ssp_pins_s;
endpackage

// *** hw/ssp_core.sv ***
/*
 Register-controlled synchronous serial master with FIFOs, three frame formats
 and interrupt identification. Assumes a single-cycle register port on sys_clk
 and an external slave whose data-out pin is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`include "ssp_params.svh"
module ssp_core (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             serial_clock_out,
   output logic             frame_select_out,
   output logic             mosi_out,
   input  wire logic        miso_in,
   output logic             combined_irq
);
   logic [15:0]       ctrl0_q;
   logic [7:0]        ctrl1_q;
   logic [7:0]        presc_q;
   logic [15:0]       txf_q [8];
   logic [15:0]       rxf_q [8];
   logic [2:0]        tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
   logic [3:0]        tx_cnt_q, rx_cnt_q;
   logic              ovr_q;
   logic [1:0]        miso_sync_q;
   logic [4:0]        base_cnt_q;
   logic              base_tick;
   logic [7:0]        pre_cnt_q, rate_cnt_q;
   logic              half_tick;
   ssp_pkg::ssp_state_e st_q;
   ssp_pkg::ssp_pins_s  pins_q;
   logic [15:0]       tx_sh_q, rx_sh_q;
   logic [4:0]        bit_q, rx_bits;
   logic              phase_q;
   logic              cw_q;
   logic              first_q;
   logic              port_en, fifo_on, spi, rx_in;
   logic              tx_push, tx_pop, rx_push, rx_pop;
   logic [3:0]        tx_cap;
   logic              tx_full, rx_full, busy;
   logic              tx_idle_irq, tx_service_irq, rx_service_irq;
   logic [7:0]        irq_flags;
   logic [8:0]        status;
   logic              frame_done;

   logic              tx_empty, tx_half, rx_half, rx_not_empty, tx_not_full;
   logic [15:0]       rx_mask;
   logic              cw_sel, pulse_sel;

   assign port_en = ctrl0_q[7];
   assign fifo_on = ctrl1_q[6];

   assign spi       = ctrl0_q[5:4] == `SSP_FMT_SPI;
   assign cw_sel    = ctrl0_q[5:4] == `SSP_FMT_CTRLW;
   assign pulse_sel = ctrl0_q[5:4] == `SSP_FMT_PULSE;
   assign tx_cap  = fifo_on ? `SSP_FIFO_DEPTH : 4'h1;
   assign tx_full = tx_cnt_q >= tx_cap;
   // Both directions share one capacity, since a single bit picks the FIFO mode.
   assign rx_full = rx_cnt_q >= tx_cap;
   assign busy    = (st_q != ssp_pkg::SSP_IDLE) || (tx_cnt_q != 4'h0);
   // A data write while full is dropped; software checks the not-full flag first.
   assign tx_push = reg_wr && reg_addr == `SSP_OFF_DATA && !tx_full;
   assign rx_pop  = reg_rd && reg_addr == `SSP_OFF_DATA && rx_cnt_q != 4'h0;
   // Loopback receive path
   // Loopback takes the registered data pin, so the receiver sees exactly what left the shifter.
   assign rx_in   = ctrl1_q[2] ? pins_q.mosi : miso_sync_q[1];

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl0_q <= `SSP_CTRL0_RST;
         ctrl1_q <= `SSP_CTRL1_RST;
         presc_q <= `SSP_PRESC_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            `SSP_OFF_CTRL0: ctrl0_q <= {reg_wdata[15:7], 1'b0, reg_wdata[5:0]};
            `SSP_OFF_CTRL1: ctrl1_q <= reg_wdata[7:0];
            `SSP_OFF_PRESC: presc_q <= {reg_wdata[7:1], 1'b0};
            default: ;
         endcase
      end
   end

   // Two flops on the data-in pin, which is asynchronous to the system clock.
   // Only the second flop feeds the receive shifter.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         miso_sync_q <= 2'b00;
      end else begin
         miso_sync_q <= {miso_sync_q[0], miso_in};
      end
   end

   // Overrun flag clears
   // A new overrun in the same cycle as a clear wins, so no event is lost.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ovr_q <= 1'b0;
      end else if (frame_done && rx_full) begin
         ovr_q <= 1'b1;
      end else if (reg_wr && reg_addr == `SSP_OFF_OVR_CLR) begin
         ovr_q <= 1'b0;
      end else if (reg_wr && reg_addr == `SSP_OFF_CTRL1 && !reg_wdata[5]) begin
         ovr_q <= 1'b0;
      end
   end

   // Base clock divider
   // The base tick is the system clock divided by a whole number, so serial rates run a few percent slow.
   // Restarting it while idle gives the data-in synchroniser time to settle before the first sample.
   assign base_tick = base_cnt_q == 5'(`SSP_BASE_DIV - 1);
   always_ff @(posedge sys_clk) begin
      if (!rst_n || base_tick || st_q == ssp_pkg::SSP_IDLE) begin
         base_cnt_q <= 5'h00;
      end else begin
         base_cnt_q <= base_cnt_q + 5'h01;
      end
   end

   assign half_tick = base_tick && pre_cnt_q == 8'h00 && rate_cnt_q == 8'h00;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pre_cnt_q  <= 8'h00;
         rate_cnt_q <= 8'h00;
      end else if (st_q == ssp_pkg::SSP_IDLE) begin
         // Preloading a full half period keeps the first half as long as the rest.
         pre_cnt_q  <= (presc_q >> 1) - 8'h01;
         rate_cnt_q <= ctrl0_q[15:8];
      end else if (base_tick) begin
         if (pre_cnt_q != 8'h00) begin
            pre_cnt_q <= pre_cnt_q - 8'h01;
         end else begin
            // Half the divisor per half period keeps the serial clock near even duty.
            pre_cnt_q  <= (presc_q >> 1) - 8'h01;
            rate_cnt_q <= (rate_cnt_q == 8'h00) ? ctrl0_q[15:8] : rate_cnt_q - 8'h01;
         end
      end
   end

   assign rx_bits = {1'b0, ctrl0_q[3:0]} + 5'h01;

   for (genvar b = 0; b < 16; b++) begin : g_rx_mask
      assign rx_mask[b] = 5'(b) < rx_bits;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !port_en) begin
         tx_wp_q  <= 3'h0;
         tx_rp_q  <= 3'h0;
         tx_cnt_q <= 4'h0;
      end else begin
         if (tx_push) begin
            tx_wp_q        <= tx_wp_q + 3'h1;
         end
         if (tx_pop) begin
            tx_rp_q <= tx_rp_q + 3'h1;
         end
         tx_cnt_q <= tx_cnt_q + {3'h0, tx_push} - {3'h0, tx_pop};
      end
   end

   for (genvar e = 0; e < 8; e++) begin : g_tx_store
      always_ff @(posedge sys_clk) begin
         if (rst_n && port_en && tx_push && tx_wp_q == 3'(e)) begin
            txf_q[e] <= reg_wdata[15:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !port_en) begin
         rx_wp_q  <= 3'h0;
         rx_rp_q  <= 3'h0;
         rx_cnt_q <= 4'h0;
      end else begin
         if (rx_push) begin
            rx_wp_q        <= rx_wp_q + 3'h1;
         end
         if (rx_pop) begin
            rx_rp_q <= rx_rp_q + 3'h1;
         end
         rx_cnt_q <= rx_cnt_q + {3'h0, rx_push} - {3'h0, rx_pop};
      end
   end

   for (genvar e = 0; e < 8; e++) begin : g_rx_store
      always_ff @(posedge sys_clk) begin
         if (rst_n && port_en && rx_push && rx_wp_q == 3'(e)) begin
            rxf_q[e] <= rx_sh_q & rx_mask;
         end
      end
   end

   assign tx_pop     = st_q == ssp_pkg::SSP_LOAD;
   // The last sample lands half a period before the frame ends, so the word is whole here.
   assign frame_done = st_q == ssp_pkg::SSP_SHIFT && half_tick && phase_q && bit_q == 5'h01;
   assign rx_push    = frame_done && !rx_full;

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !port_en) begin
         st_q    <= ssp_pkg::SSP_IDLE;
         tx_sh_q <= 16'h0000;
         rx_sh_q <= 16'h0000;
         bit_q   <= 5'h00;
         phase_q <= 1'b0;
         cw_q    <= 1'b0;
         first_q <= 1'b0;
      end else begin
         case (st_q)
            ssp_pkg::SSP_IDLE: begin
               if (tx_cnt_q != 4'h0) begin
                  st_q <= ssp_pkg::SSP_LOAD;
               end
            end
            ssp_pkg::SSP_LOAD: begin
               cw_q    <= cw_sel;
               first_q <= 1'b1;
               phase_q <= 1'b0;
               rx_sh_q <= 16'h0000;
               if (cw_sel) begin
                  // Eight bit send
                  // One idle bit separates the control word from the reply.
                  tx_sh_q <= {txf_q[tx_rp_q][7:0], 8'h00};
                  bit_q   <= `SSP_CW_BITS + rx_bits + 5'h01;
               end else begin
                  tx_sh_q <= txf_q[tx_rp_q] << (5'h10 - rx_bits);
                  bit_q   <= rx_bits;
               end
               st_q <= ssp_pkg::SSP_SHIFT;
            end
            ssp_pkg::SSP_SHIFT: begin
               if (half_tick) begin
                  phase_q <= !phase_q;
                  if (!phase_q) begin
                     if (!cw_q || bit_q <= rx_bits) begin
                        rx_sh_q <= {rx_sh_q[14:0], rx_in};
                     end
                  end else begin
                     first_q <= 1'b0;
                     tx_sh_q <= {tx_sh_q[14:0], 1'b0};
                     bit_q   <= bit_q - 5'h01;
                     if (bit_q == 5'h01) begin
                        st_q <= (spi && !ctrl1_q[4]) ? ssp_pkg::SSP_GAP : ssp_pkg::SSP_IDLE;
                        if (spi && ctrl1_q[4] && tx_cnt_q != 4'h0) begin
                           st_q <= ssp_pkg::SSP_LOAD;
                        end
                     end
                  end
               end
            end
            // The gap holds frame select high for one full serial clock period.
            ssp_pkg::SSP_GAP: begin
               if (half_tick) begin
                  phase_q <= !phase_q;
                  if (phase_q) begin
                     st_q <= ssp_pkg::SSP_IDLE;
                  end
               end
            end
            default: st_q <= ssp_pkg::SSP_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // Frame select idles high, the inactive level of the active-low formats.
         pins_q <= '{sclk: 1'b0, frame: 1'b1, mosi: 1'b0};
      end else begin
         pins_q.sclk <= spi && ctrl1_q[3];
         pins_q.mosi <= tx_sh_q[15];
         if (pulse_sel) begin
            pins_q.frame <= st_q == ssp_pkg::SSP_SHIFT && first_q;
         end else begin
            pins_q.frame <= !(st_q == ssp_pkg::SSP_SHIFT || st_q == ssp_pkg::SSP_LOAD);
         end
         if (st_q == ssp_pkg::SSP_SHIFT) begin
            pins_q.sclk <= (spi && ctrl1_q[3]) ^ (phase_q ^ (spi && ctrl1_q[4]));
         end
      end
   end
   assign serial_clock_out = pins_q.sclk;
   assign frame_select_out = pins_q.frame;
   assign mosi_out         = pins_q.mosi;

   assign tx_empty     = tx_cnt_q == 4'h0;
   assign tx_not_full  = !tx_full;
   assign rx_not_empty = rx_cnt_q != 4'h0;
   assign rx_half      = rx_cnt_q >= (fifo_on ? `SSP_WATERMARK : 4'h1);
   assign tx_half      = tx_cnt_q <= (fifo_on ? `SSP_WATERMARK : 4'h0);

   assign tx_idle_irq = ctrl1_q[7] && port_en && !busy;
   // Service interrupt gates
   // A disabled port asks for data, though its FIFO is held empty and drops data writes until enabling.
   assign tx_service_irq = ctrl1_q[1] && (!port_en || tx_half);
   assign rx_service_irq = ctrl1_q[0] && rx_half;
   assign irq_flags = {tx_idle_irq, ovr_q && ctrl1_q[5], 4'h0, tx_service_irq, rx_service_irq};
   assign combined_irq = |irq_flags;
   assign status = {rx_full && port_en, tx_empty, ovr_q, rx_half, port_en && tx_half,
                    busy, rx_not_empty, tx_not_full, 1'b0};

   // Read data fall back to zero outside the answer cycle, so a late sample shows nothing.
   // Read decode
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `SSP_OFF_CTRL0: reg_rdata <= {16'h0000, ctrl0_q};
            `SSP_OFF_CTRL1: reg_rdata <= {24'h000000, ctrl1_q};
            `SSP_OFF_IRQ:   reg_rdata <= {24'h000000, irq_flags};
            `SSP_OFF_DATA:  reg_rdata <= {16'h0000, rxf_q[rx_rp_q]};
            `SSP_OFF_PRESC: reg_rdata <= {24'h000000, presc_q};
            `SSP_OFF_STAT:  reg_rdata <= {23'h000000, status};
            default:        reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end
endmodule

// *** testbench/ssp_core_chk.sv ***
/* Port-level checker for the serial port core.
   Assumes it is bound to ssp_core and sees only its ports. */
`timescale 1ns/1ps
module ssp_core_chk (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        serial_clock_out,
   input wire logic        frame_select_out,
   input wire logic        mosi_out,
   input wire logic        miso_in,
   input wire logic        combined_irq
);
   logic [15:0] c0_q;
   logic [7:0]  c1_q;
   // Shadow copies of the two control registers, updated on the same edge as the core's.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         c0_q <= 16'h0000;
         c1_q <= 8'h00;
      end else if (reg_wr && reg_addr == 8'h00) begin
         c0_q <= reg_wdata[15:0];
      end else if (reg_wr && reg_addr == 8'h04) begin
         c1_q <= reg_wdata[7:0];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read answer");
   a_irq_or_flags: assert property ($past(reg_rd) && $past(reg_addr) == 8'h08 |-> (|reg_rdata) == $past(combined_irq))
      else $error("combined interrupt differs from flags");
   a_iir_resv_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h08 |->
      reg_rdata[31:8] == 24'h0 && reg_rdata[5:2] == 4'h0)
      else $error("identification reserved bits not zero");
   a_ctrl0_resv: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> reg_rdata[31:16] == 16'h0 && !reg_rdata[6])
      else $error("ctrl0 reserved bits not zero");
   a_ctrl1_resv: assert property ($past(reg_rd) && $past(reg_addr) == 8'h04 |-> reg_rdata[31:8] == 24'h0)
      else $error("ctrl1 reserved bits not zero");
   a_presc_even: assert property ($past(reg_rd) && $past(reg_addr) == 8'h10 |-> reg_rdata[31:8] == 24'h0 && !reg_rdata[0])
      else $error("prescaler readback not even");
   a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) >= 8'h18 |-> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_sclk_idle_pol: assert property ((!c0_q[7] && c0_q[5:4] == 2'h0 && $stable(c1_q[3])) [*4] |->
      serial_clock_out == c1_q[3])
      else $error("serial clock idle level wrong");
   a_frame_idle_hi: assert property ((!c0_q[7] && c0_q[5:4] != 2'h1 && $stable(c0_q[5:4])) [*4] |->
      frame_select_out)
      else $error("frame select active while disabled");
   a_irq_masked: assert property ((c1_q & 8'hA3) == 8'h00 |-> !combined_irq)
      else $error("interrupt raised with enables off");
   c_overrun: cover property ($past(reg_rd) && $past(reg_addr) == 8'h08 && reg_rdata[6]);
   c_irq: cover property (combined_irq);
   c_frame: cover property ($fell(frame_select_out));
endmodule
bind ssp_core ssp_core_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clock_out(serial_clock_out),
   .frame_select_out(frame_select_out), .mosi_out(mosi_out), .miso_in(miso_in), .combined_irq(combined_irq));

// *** testbench/ssp_slave_model.sv ***
/* Behavioural serial slave, polarity 0 and phase 0, sixteen-bit shifter.
   Assumes an active-low frame select and a clock that idles low. */
`timescale 1ns/1ps
module ssp_slave_model #(
   parameter logic [15:0] REPLY = 16'hA5C3
) (
   input  wire logic        sclk,
   input  wire logic        frame_n,
   input  wire logic        mosi,
   output logic             miso,
   output logic [15:0]      rx_word
);
   logic [15:0] sh;
   initial begin
      miso = 1'b0;
      rx_word = 16'h0000;
      sh = REPLY;
   end
   always @(negedge frame_n) begin
      sh = REPLY;
      miso = REPLY[15];
   end
   always @(posedge sclk) if (!frame_n) rx_word = {rx_word[14:0], mosi};
   always @(negedge sclk) if (!frame_n) begin
      sh = {sh[14:0], 1'b0};
      miso = sh[15];
   end
   // Released line shows the inverse, so a stale sample cannot pass.
   always @(posedge frame_n) miso = ~miso;
endmodule

// *** testbench/test_sync_serial_port_regs.sv ***
/* Self-checking bench for the serial port core.
   Assumes the core, its checker and the slave model are compiled before it. */
`timescale 1ns/1ps
module test_sync_serial_port_regs;
   localparam logic [15:0] REPLY = 16'hA5C3;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata, v;
   logic        sclk, frame_n, mosi, miso, irq;
   logic [15:0] slv_word, c;
   int          n_errors = 0, samples_checked = 0, seed = 89, cyc = 0;
   always #2.5 sys_clk = ~sys_clk;
   ssp_core u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clock_out(sclk), .frame_select_out(frame_n),
      .mosi_out(mosi), .miso_in(miso), .combined_irq(irq));
   ssp_slave_model #(.REPLY(REPLY)) u_slv (.sclk(sclk), .frame_n(frame_n), .mosi(mosi), .miso(miso),
      .rx_word(slv_word));
   task automatic report_and_stop;
      $display("Counts: %0d checked, %0d mismatches", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      if (a != 8'h14) chk(v, exp);
   endtask
   // Busy is polled with a bound, so a stuck engine ends in a mismatch, not a hang.
   task automatic send(input logic [15:0] d);
      wr(8'h0C, {16'h0, d});
      for (int i = 0; i < 1000; i++) begin
         rchk(8'h14, 32'h0);
         if (v[3] === 1'b0) break;
      end
   endtask
   function automatic logic [15:0] exp_rx(input logic lb, input logic [1:0] fmt, input logic [15:0] d,
                                          input logic [3:0] sz);
      if (!lb) return REPLY >> (4'hF - sz);
      // Loopback in control-word format hears only the idle line after the eight sent bits.
      return (fmt == 2'h2) ? 16'h0000 : d;
   endfunction
   task automatic xfer(input logic lb, input logic [3:0] sz, input logic [1:0] fmt, input logic clock_phase_sel);
      logic [15:0] d, m;
      m = 16'hFFFF >> (4'hF - sz);
      d = 16'($random(seed)) & m;
      wr(8'h00, {16'h0, 8'h00, 2'b10, fmt, sz});
      wr(8'h04, {27'h0, clock_phase_sel, 1'b0, lb, 2'h0});
      send(d);
      rchk(8'h0C, {16'h0, exp_rx(lb, fmt, d, sz)});
      if (!lb) chk({16'h0, slv_word & m}, {16'h0, d});
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         report_and_stop;
      end
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      rchk(8'h00, 32'h0);
      rchk(8'h04, 32'h0);
      rchk(8'h10, 32'h4);
      rchk(8'h08, 32'h0);
      $display("test reset_values done");
      wr(8'h00, 32'h80);
      for (int i = 0; i < 6; i++) begin
         v = $random(seed);
         c = {v[15:8], 2'b10, 2'(i % 3), 4'h3 + 4'(v[7:4] % 13)};
         wr(8'h00, {16'h0, c});
         rchk(8'h00, {16'h0, c});
         wr(8'h04, {24'h0, v[23:16]});
         rchk(8'h04, {24'h0, v[23:16]});
         wr(8'h10, {24'h0, v[31:24]});
         rchk(8'h10, {24'h0, v[31:24] & 8'hFE});
         rchk(8'h18 + 8'(i * 40), 32'h0);
      end
      $display("test registers done");
      wr(8'h04, 32'h0);
      wr(8'h10, 32'h2);
      xfer(1'b1, 4'hB, 2'h0, 1'b1);
      xfer(1'b1, 4'h7, 2'h1, 1'b0);
      xfer(1'b1, 4'h7, 2'h2, 1'b0);
      for (int j = 0; j < 6; j++) xfer(j < 3, 4'h3 + 4'(6 * (j % 3)), 2'h0, 1'b0);
      $display("test transfers done");
      wr(8'h04, 32'h24);
      send(16'h0011);
      send(16'h0022);
      rchk(8'h08, 32'h40);
      wr(8'h08, 32'h5A);
      rchk(8'h08, 32'h0);
      send(16'h0033);
      wr(8'h04, 32'h04);
      wr(8'h04, 32'h24);
      rchk(8'h08, 32'h0);
      rchk(8'h0C, 32'h0011);
      $display("test overrun done");
      wr(8'h04, 32'hC2);
      rchk(8'h08, 32'h82);
      chk({31'h0, irq}, 32'h1);
      wr(8'h04, 32'h40);
      rchk(8'h08, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(8'h00, 32'h0);
      repeat (4) @(posedge sys_clk);
      chk({30'h0, sclk, frame_n}, 32'h1);
      $display("test interrupts done");
      report_and_stop;
   end
endmodule
